/* File: rtl/cio_defs.svh */
// Register offsets, reset values and field codes of the configurable I/O port
`ifndef CIO_DEFS_SVH
`define CIO_DEFS_SVH
`define CIO_PORT_DATA_OFS 12'h000
`define CIO_PORT_DIRECTION_OFS 12'h004
`define CIO_PORT_OPTION_SELECT_OFS 12'h008
`define CIO_INTERRUPT_OPTION_OFS 12'h00C
`define CIO_IRQ_STATUS_OFS 12'h010
`define CIO_IRQ_MASK_OFS 12'h014
`define CIO_PORT_RESET 8'h00
`define CIO_IOR_RESET 8'h00
`define CIO_GEN_BIT 0
`define CIO_TRIG_LSB 1
`define CIO_TRIG_FALL 2'h0
`define CIO_TRIG_RISE 2'h1
`define CIO_TRIG_LOW 2'h2
`define CIO_ST_PIN_EVENT 0
`define CIO_ST_ANALOG_CLASH 1
`endif

/* File: rtl/cio_pkg.sv */
// Types shared by the configurable I/O port
package cio_pkg;
	typedef struct packed
	{
		logic [7:0] drive_high;
		logic [7:0] drive_low;
		logic [7:0] pull_up;
		logic [7:0] analog_sel;
	} cio_pad_t;
	typedef enum logic [2:0]
	{
		CIO_IDLE = 3'b001,
		CIO_ACCESS = 3'b010,
		CIO_DONE = 3'b100
	} cio_bus_state_t;
	typedef struct packed
	{
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] opt;
		logic [7:0] interrupt_option_reg;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic [7:0] pin_prev;
		logic [31:0] prdata;
		logic pslverr;
		cio_bus_state_t bus;
		cio_pad_t pad;
	} cio_state_t;
endpackage : cio_pkg

/* File: rtl/cio_port.sv */
// Configurable eight-pin I/O port with an APB register slave
//
// Behaviour
// - Bit x of the data, direction and option registers controls pin x
// - Reset clears all registers: pulled-up inputs
// - Input pins read back the live pin level
// - Output pins drive and read back the latch
// - Option and data pick the input variant
// - Option picks open-drain or push-pull output
// - Open-drain never drives high, push-pull does
// - Analog pins route to ADC, one at once; more than one sets the analog clash status bit
// - Pin interrupt needs interrupt mode and global enable
// - Per-port trigger: falling, rising or low level
// - Low power keeps state; pin interrupt wakes device
// - Global enable clear blocks new pin events; a pin status bit already set still drives irq and wake
`timescale 1ns/10ps
`default_nettype none
`include "cio_defs.svh"

module cio_port #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	output cio_pkg::cio_pad_t pad_ctrl,
	output logic irq,
	output logic wake_req
);
	import cio_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	cio_state_t s_q;
	cio_state_t s_d;
	logic [7:0] input_mode;
	logic [7:0] irq_mode;
	logic [7:0] analog_mode;
	logic [7:0] rd_port;
	logic [7:0] trig_hit;
	logic pin_event;
	logic clash;
	logic [7:0] wv;
	logic [1:0] trig;

	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign pready = (s_q.bus == CIO_ACCESS);
	assign pin_out = s_q.pad.drive_low == 8'h00 ? s_q.pad.drive_high[WIDTH-1:0] : ~s_q.pad.drive_low[WIDTH-1:0];
	assign pin_oe_n = ~(s_q.pad.drive_high[WIDTH-1:0] | s_q.pad.drive_low[WIDTH-1:0]);
	assign pad_ctrl = s_q.pad;
	// Level output straight from sticky bits and mask, so it survives a stopped CPU
	assign irq = |(s_q.irq_status & s_q.irq_mask);
	assign wake_req = irq && s_q.irq_status[`CIO_ST_PIN_EVENT];

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d = s_q;
		wv = pwdata[7:0];
		trig = s_q.interrupt_option_reg[`CIO_TRIG_LSB +: 2];
		// Each pin decodes only its own bit of the three registers
		input_mode = ~s_q.dir;
		irq_mode = input_mode & s_q.opt & ~s_q.data;
		analog_mode = input_mode & s_q.opt & s_q.data;
		rd_port = (s_q.dir & s_q.data) | (input_mode & s_q.pin_s2);
		// Trigger choice applies to every interrupt pin of the port
		if (trig == `CIO_TRIG_RISE)
		begin
			trig_hit = s_q.pin_s2 & ~s_q.pin_prev;
		end
		else if (trig == `CIO_TRIG_LOW)
		begin
			trig_hit = ~s_q.pin_s2;
		end
		else
		begin
			trig_hit = ~s_q.pin_s2 & s_q.pin_prev;
		end
		pin_event = s_q.interrupt_option_reg[`CIO_GEN_BIT] && ((trig_hit & irq_mode) != 8'h00);
		// More than one analog pin shorts them together inside the mux
		clash = (analog_mode & (analog_mode - 8'h01)) != 8'h00;

		s_d.pin_s1 = {{(8-WIDTH){1'b0}}, pin_in};
		s_d.pin_s2 = s_q.pin_s1;
		s_d.pin_prev = s_q.pin_s2;

		// Pad drive is registered, so a write takes effect the cycle after it lands
		s_d.pad.drive_low = s_q.dir & ~s_q.data;
		s_d.pad.drive_high = s_q.dir & s_q.opt & s_q.data;
		s_d.pad.pull_up = input_mode & ~s_q.data;
		s_d.pad.analog_sel = analog_mode;

		case (s_q.bus)
			CIO_IDLE:
			begin
				if (psel && !penable)
				begin
					// Read data is fetched at setup so it stands while pready is high
					s_d.bus = CIO_ACCESS;
					s_d.pslverr = 1'b0;
					s_d.prdata = 32'h0000_0000;
					if (paddr == `CIO_PORT_DATA_OFS)
					begin
						s_d.prdata[7:0] = rd_port;
					end
					else if (paddr == `CIO_PORT_DIRECTION_OFS)
					begin
						s_d.prdata[7:0] = s_q.dir;
					end
					else if (paddr == `CIO_PORT_OPTION_SELECT_OFS)
					begin
						s_d.prdata[7:0] = s_q.opt;
					end
					else if (paddr == `CIO_INTERRUPT_OPTION_OFS)
					begin
						s_d.prdata[7:0] = s_q.interrupt_option_reg;
					end
					else if (paddr == `CIO_IRQ_STATUS_OFS)
					begin
						s_d.prdata[1:0] = s_q.irq_status;
					end
					else if (paddr == `CIO_IRQ_MASK_OFS)
					begin
						s_d.prdata[1:0] = s_q.irq_mask;
					end
					else
					begin
						// Unmapped reads answer zero with an error flag
						s_d.pslverr = 1'b1;
					end
				end
			end
			CIO_ACCESS:
			begin
				s_d.bus = CIO_IDLE;
				if (pwrite)
				begin
					if (paddr == `CIO_PORT_DATA_OFS)
					begin
						s_d.data = wv;
					end
					else if (paddr == `CIO_PORT_DIRECTION_OFS)
					begin
						s_d.dir = wv;
					end
					else if (paddr == `CIO_PORT_OPTION_SELECT_OFS)
					begin
						s_d.opt = wv;
					end
					else if (paddr == `CIO_INTERRUPT_OPTION_OFS)
					begin
						s_d.interrupt_option_reg = {5'h00, wv[2:0]};
					end
					else if (paddr == `CIO_IRQ_STATUS_OFS)
					begin
						s_d.irq_status = s_q.irq_status & ~wv[1:0];
					end
					else if (paddr == `CIO_IRQ_MASK_OFS)
					begin
						s_d.irq_mask = wv[1:0];
					end
				end
			end
			default:
			begin
				s_d.bus = CIO_IDLE;
			end
		endcase

		// Hardware set wins over a software clear in the same cycle
		if (pin_event)
		begin
			s_d.irq_status[`CIO_ST_PIN_EVENT] = 1'b1;
		end
		if (clash)
		begin
			s_d.irq_status[`CIO_ST_ANALOG_CLASH] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.data <= `CIO_PORT_RESET;
			s_q.dir <= `CIO_PORT_RESET;
			s_q.opt <= `CIO_PORT_RESET;
			s_q.interrupt_option_reg <= `CIO_IOR_RESET;
			s_q.irq_status <= 2'h0;
			s_q.irq_mask <= 2'h0;
			s_q.pin_s1 <= 8'hFF;
			s_q.pin_s2 <= 8'hFF;
			s_q.pin_prev <= 8'hFF;
			s_q.prdata <= 32'h0000_0000;
			s_q.pslverr <= 1'b0;
			s_q.bus <= CIO_IDLE;
			s_q.pad.drive_high <= 8'h00;
			s_q.pad.drive_low <= 8'h00;
			s_q.pad.pull_up <= 8'hFF;
			s_q.pad.analog_sel <= 8'h00;
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule : cio_port
`default_nettype wire

/* File: dv/cio_port_assertions.sv */
// Port assertions of the configurable I/O port
`timescale 1ns/10ps
`default_nettype none
module cio_port_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [7:0] pin_oe_n,
	input wire cio_pkg::cio_pad_t pad_ctrl,
	input wire logic irq,
	input wire logic wake_req
);
	import cio_pkg::*;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("late answer");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("long answer");
	property p_cfg; $changed(pin_oe_n) |-> $past(psel && penable && pwrite, 2); endproperty
	a_cfg: assert property (p_cfg) else $error("pin change without write");
	property p_rst; $rose(presetn) |-> pin_oe_n == 8'hFF && pad_ctrl.pull_up == 8'hFF; endproperty
	a_rst: assert property (p_rst) else $error("bad reset pins");
	property p_an; (pad_ctrl.analog_sel & pad_ctrl.pull_up) == 8'h00; endproperty
	a_an: assert property (p_an) else $error("pulled analog pin");
	property p_drv; (pad_ctrl.analog_sel & ~pin_oe_n) == 8'h00; endproperty
	a_drv: assert property (p_drv) else $error("driven analog pin");
	property p_pull; (pad_ctrl.pull_up & ~pin_oe_n) == 8'h00; endproperty
	a_pull: assert property (p_pull) else $error("pulled output");
	property p_wake; wake_req |-> irq; endproperty
	a_wake: assert property (p_wake) else $error("wake without irq");
endmodule : cio_port_assertions
`default_nettype wire

/* File: dv/cio_pins_model.sv */
// Board-side model of the port pins
`timescale 1ns/10ps
`default_nettype none
module cio_pins_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pull_up,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	// A floating unpulled pin shows the inverse of pin_out, so a stale level never passes
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pull_up | ~pin_out));
endmodule : cio_pins_model
`default_nettype wire

/* File: dv/cio_port_tb.sv */
// Self-checking bench of the configurable I/O port
`timescale 1ns/10ps
`default_nettype none
module cio_port_tb;
	import cio_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, wake_req;
	logic [7:0] pin_in, pin_out, pin_oe_n;
	logic [7:0] ext_en = 8'hFF;
	logic [7:0] ext_val = 8'hFF;
	cio_pad_t pad;
	int err_count = 0;
	int checks = 0;
	logic [31:0] rdata = 32'h0;
	logic rerr = 1'h0;
	always #20 pclk = ~pclk;
	cio_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pin_in, .pin_out, .pin_oe_n, .pad_ctrl(pad), .irq, .wake_req);
	cio_pins_model pm (.pin_out, .pin_oe_n, .pull_up(pad.pull_up), .ext_en, .ext_val, .pin_in);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Read data and error are taken at the edge where pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic t_output;
		for (int a = 4; a < 16; a += 4)
		begin
			apb(1'h0, 12'(a), 8'h00);
			chk(rdata, 32'h0);
		end
		wr(12'h004, 8'hFF);
		wr(12'h008, 8'hF0);
		wr(12'h000, 8'hA5);
		@(posedge pclk);
		chk(pin_oe_n, 8'h05);
		chk(pin_out & ~pin_oe_n, 8'hA0);
		apb(1'h0, 12'h000, 8'h00);
		chk(rdata, 32'hA5);
	endtask : t_output
	task automatic t_input;
		ext_val <= 8'h3C;
		wr(12'h004, 8'h00);
		wr(12'h008, 8'h01);
		wr(12'h000, 8'h0F);
		@(posedge pclk);
		chk(pad.pull_up, 8'hF0);
		chk(pad.analog_sel, 8'h01);
		apb(1'h0, 12'h000, 8'h00);
		chk(rdata, 32'h3C);
		apb(1'h0, 12'h018, 8'h00);
		chk(rerr, 1'h1);
		chk(rdata, 32'h0);
	endtask : t_input
	task automatic t_irq;
		wr(12'h008, 8'h02);
		wr(12'h000, 8'h00);
		wr(12'h014, 8'h01);
		for (int t = 0; t < 3; t++)
		begin
			wr(12'h00C, {5'h0, 2'(t), 1'h1});
			ext_val <= 8'hFF;
			repeat (5) @(posedge pclk);
			wr(12'h010, 8'h03);
			ext_val <= 8'hFD;
			repeat (5) @(posedge pclk);
			chk(irq, t != 1);
			wr(12'h010, 8'h03);
			@(posedge pclk);
			chk(irq, t == 2);
			ext_val <= 8'hFF;
			repeat (5) @(posedge pclk);
			chk(irq, t != 0);
		end
		wr(12'h00C, 8'h04);
		wr(12'h010, 8'h03);
		ext_val <= 8'hFD;
		repeat (5) @(posedge pclk);
		chk(irq, 1'h0);
		wr(12'h014, 8'h00);
		wr(12'h00C, 8'h05);
		repeat (5) @(posedge pclk);
		chk(irq, 1'h0);
		apb(1'h0, 12'h010, 8'h00);
		chk(rdata[0], 1'h1);
		wr(12'h014, 8'h01);
		@(posedge pclk);
		chk(irq, 1'h1);
		chk(wake_req, 1'h1);
		wr(12'h004, 8'hFF);
		wr(12'h008, 8'hFF);
		wr(12'h000, 8'h00);
		@(posedge pclk);
		chk(pin_oe_n, 8'h00);
		chk(pin_out, 8'h00);
	endtask : t_irq
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_output();
		t_input();
		t_irq();
		give_verdict();
	end
	initial
	begin
		#100us;
		err_count++;
		give_verdict();
	end
endmodule : cio_port_tb
bind cio_port cio_port_assertions chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pin_oe_n,
	.pad_ctrl, .irq, .wake_req);
`default_nettype wire
